// ===== logic/cai_map.vh
// ==========================================================
// channel alarm and interrupt register map
// ==========================================================
`ifndef CAI_MAP_VH
`define CAI_MAP_VH

// channel count and address split
`define CAI_NUM_CH        6
`define CAI_LAST_CH       3'h5

// per-channel register offsets (low nibble of the address)
`define CAI_OFS_IRQ_EN    4'h1
`define CAI_OFS_IRQ_STAT  4'h2
`define CAI_OFS_ALARM     4'h3
`define CAI_OFS_TX_CTL    4'h4
`define CAI_OFS_RX_CTL    4'h5
`define CAI_OFS_BLK_CTL   4'h6
`define CAI_OFS_JA_CTL    4'h7
`define CAI_OFS_CNT_HI    4'hA
`define CAI_OFS_CNT_LO    4'hB
`define CAI_OFS_CNT_HOLD  4'hC

// enable, status and alarm bit positions
`define CAI_B_DRV_QUIET   0
`define CAI_B_RX_LOS      1
`define CAI_B_RX_LOL      2
`define CAI_B_FIFO_LIM    3
`define CAI_B_PRBS_ERR    4
`define CAI_B_CNT_SAT     5

// control field positions
`define CAI_B_TXMON       5
`define CAI_B_JA0         0
`define CAI_B_JA1         2

// writable bit masks, reserved bits read as zero
`define CAI_MASK_EN       8'h3F
`define CAI_MASK_TX       8'h37
`define CAI_MASK_RX       8'h3F
`define CAI_MASK_BLK      8'h7F
`define CAI_MASK_JA       8'h0F

// reset values
`define CAI_RST_REG       8'h00
`define CAI_RST_CNT       16'h0000

// timing counts: quiet time in core clock cycles, lock window and tolerance in reference ticks
`define CAI_QUIET_CYCLES  8'h80
`define CAI_LOCK_WIN      11'h3E8
`define CAI_LOCK_TOL      11'h005
`define CAI_CNT_MAX       16'hFFFF

`endif

// ===== logic/cai_chan.v
`timescale 1ns/1ps
`default_nettype none
`include "cai_map.vh"

// ==========================================================
// one channel: alarm monitors, status latch, interrupt gate
// ==========================================================
module cai_chan (
    // clock and reset
    input  wire       clk_i,
    input  wire       rst_n_i,
    // line-side indications, same clock domain
    input  wire       tx_pulse_i,
    input  wire       rx_los_i,
    input  wire       rclk_tick_i,
    input  wire       ref_tick_i,
    input  wire       fifo_lim_i,
    input  wire       prbs_err_i,
    input  wire       cnt_sat_i,
    // control from the register file
    input  wire       txmon_en_i,
    input  wire       ja_on_i,
    input  wire [7:0] irq_en_i,
    input  wire       clr_stat_i,
    // results
    output reg  [7:0] stat_o,
    output wire [7:0] alarm_o,
    output wire       irq_o
);

    reg  [7:0]  quiet_cnt;   // cycles since the last driver pulse
    reg         quiet;       // driver quiet alarm level
    reg  [10:0] ref_cnt;     // reference ticks in the lock window
    reg  [10:0] rec_cnt;     // recovered ticks in the lock window
    reg         lol;         // lock loss alarm level
    reg  [3:0]  alarm_d;     // alarm levels one cycle ago
    wire [3:0]  alarm_now;   // current alarm levels
    wire [5:0]  ev;          // status set events
    wire [5:0]  en_eff;      // enables after the fifo gate

    // ==========================================================
    // driver monitor
    // ==========================================================
    // counts idle cycles; a pulse or a disabled monitor restarts it
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            quiet_cnt <= 8'h00;
            quiet     <= 1'b0;
        end else if (tx_pulse_i || !txmon_en_i) begin
            quiet_cnt <= 8'h00;
            quiet     <= 1'b0;
        end else if (quiet_cnt == `CAI_QUIET_CYCLES - 8'h01) begin
            quiet     <= 1'b1;
        end else begin
            quiet_cnt <= quiet_cnt + 8'h01;
        end
    end

    // ==========================================================
    // lock monitor
    // ==========================================================
    // compares recovered ticks against a window of reference ticks;
    // the counter saturates so a runaway clock cannot wrap into lock
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt <= 11'h000;
            rec_cnt <= 11'h000;
            lol     <= 1'b0;
        end else if (ref_tick_i && ref_cnt == `CAI_LOCK_WIN - 11'h001) begin
            ref_cnt <= 11'h000;
            rec_cnt <= {10'h000, rclk_tick_i};
            lol     <= (rec_cnt > `CAI_LOCK_WIN + `CAI_LOCK_TOL) ||
                       (rec_cnt < `CAI_LOCK_WIN - `CAI_LOCK_TOL);
        end else begin
            if (ref_tick_i)
                ref_cnt <= ref_cnt + 11'h001;
            if (rclk_tick_i && rec_cnt != 11'h7FF)
                rec_cnt <= rec_cnt + 11'h001;
        end
    end

    // ==========================================================
    // change detect and status latch
    // ==========================================================
    // fifo level is meaningless with the attenuator off
    assign alarm_now = {fifo_lim_i & ja_on_i, lol, rx_los_i, quiet};
    assign alarm_o   = {4'h0, alarm_now};

    // every change of an alarm level counts, in either direction
    assign ev = {cnt_sat_i, prbs_err_i, alarm_now ^ alarm_d};

    // previous levels for the change detector
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            alarm_d <= 4'h0;
        else
            alarm_d <= alarm_now;
    end

    // set wins over the clear of a read in the same cycle
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            stat_o <= `CAI_RST_REG;
        else
            stat_o <= (stat_o & {8{~clr_stat_i}}) | {2'b00, ev};
    end

    // fifo enable is ignored while the attenuator is off
    assign en_eff = irq_en_i[5:0] & {2'b11, ja_on_i, 3'b111};

    // interrupt gated by the per-source enables
    assign irq_o = |(stat_o[5:0] & en_eff);

endmodule
`default_nettype wire

// ===== logic/cai_regs.v
`timescale 1ns/1ps
`default_nettype none
`include "cai_map.vh"


// ==========================================================
// six-channel alarm and interrupt register file
// ==========================================================
module cai_regs (
    // clock and reset
    input  wire        CORE_CLK_I,
    input  wire        RSTN_I,
    // parallel processor port
    input  wire [6:0]  ADDR_I,
    input  wire [7:0]  DATA_I,
    output reg  [7:0]  DATA_O,
    output reg         DATA_OE_O,
    input  wire        CS_N_I,
    input  wire        RD_N_I,
    input  wire        WR_N_I,
    output reg         RDY_O,
    // line-side indications, one bit per channel
    input  wire [5:0]  TX_PULSE_I,
    input  wire [5:0]  RX_LOS_I,
    input  wire [5:0]  RCLK_TICK_I,
    input  wire [5:0]  REF_TICK_I,
    input  wire [5:0]  JA_LIMIT_I,
    input  wire [5:0]  PRBS_ERR_I,
    // per-channel interrupts
    output wire [5:0]  CH_IRQ_O,
    // control registers, channel n in bits 8n+7..8n
    output wire [47:0] TX_CTL_O,
    output wire [47:0] RX_CTL_O,
    output wire [47:0] BLK_CTL_O,
    output wire [47:0] JA_CTL_O
);

    // ==========================================================
    // address decode helpers
    // ==========================================================
    // channel number from the high address bits
    function [2:0] ch_of;
        input [6:0] a;
        begin
            ch_of = a[6:4];
        end
    endfunction

    // true when the access lands on one of the six channels
    function ch_ok;
        input [6:0] a;
        begin
            ch_ok = (a[6:4] <= `CAI_LAST_CH);
        end
    endfunction

    // true when the access lands on a given offset
    function hit;
        input [6:0] a;
        input [3:0] ofs;
        begin
            hit = ch_ok(a) && (a[3:0] == ofs);
        end
    endfunction

    // ==========================================================
    // strobe synchronisers
    // ==========================================================
    reg  [2:0] cs_s;    // chip select shift, active low
    reg  [2:0] rd_s;    // read strobe shift, active low
    reg  [2:0] wr_s;    // write strobe shift, active low
    reg        cs_f;    // filtered chip select, active low
    reg        rd_f;    // filtered read strobe, active low
    reg        wr_f;    // filtered write strobe, active low
    reg        rd_act_d; // read active one cycle ago
    reg        wr_act_d; // write active one cycle ago
    wire       rd_act;  // read access in progress
    wire       wr_act;  // write access in progress
    wire       rd_go;   // first cycle of a read
    wire       wr_go;   // first cycle of a write

    // three flops per strobe; only the last two are compared
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cs_s <= 3'h7;
            rd_s <= 3'h7;
            wr_s <= 3'h7;
        end else begin
            cs_s <= {cs_s[1:0], CS_N_I};
            rd_s <= {rd_s[1:0], RD_N_I};
            wr_s <= {wr_s[1:0], WR_N_I};
        end
    end

    // a level change counts once the second and third flops agree
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            cs_f <= 1'b1;
            rd_f <= 1'b1;
            wr_f <= 1'b1;
        end else begin
            if (cs_s[1] == cs_s[2])
                cs_f <= cs_s[2];
            if (rd_s[1] == rd_s[2])
                rd_f <= rd_s[2];
            if (wr_s[1] == wr_s[2])
                wr_f <= wr_s[2];
        end
    end

    assign rd_act = ~cs_f & ~rd_f;
    assign wr_act = ~cs_f & ~wr_f;

    // edge detect of the filtered accesses
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            rd_act_d <= 1'b0;
            wr_act_d <= 1'b0;
        end else begin
            rd_act_d <= rd_act;
            wr_act_d <= wr_act;
        end
    end

    // address and data are held steady by the host for the strobe,
    // so they are sampled directly once the strobe is confirmed
    assign rd_go = rd_act & ~rd_act_d;
    assign wr_go = wr_act & ~wr_act_d;

    // ==========================================================
    // per-channel storage
    // ==========================================================
    reg  [7:0]  en_r   [0:5]; // interrupt enables
    reg  [7:0]  tx_r   [0:5]; // transmit control
    reg  [7:0]  rx_r   [0:5]; // receive control
    reg  [7:0]  blk_r  [0:5]; // block control
    reg  [7:0]  ja_r   [0:5]; // jitter attenuator control
    reg  [7:0]  hold_r [0:5]; // low count byte caught at high read
    reg  [15:0] cnt_r  [0:5]; // prbs error counters
    wire [7:0]  stat_w [0:5]; // latched interrupt status
    wire [7:0]  alarm_w[0:5]; // live alarm levels
    wire [5:0]  clr_stat;     // status clear, one per channel
    wire [5:0]  cnt_rd;       // count high byte read, per channel
    wire [5:0]  sat_ev;       // counter reaches its ceiling
    wire [5:0]  ja_on;        // attenuator in use
    integer     i;

    // ==========================================================
    // control register writes
    // ==========================================================
    // reserved bits are masked off so they always read as zero
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            for (i = 0; i < `CAI_NUM_CH; i = i + 1) begin
                en_r[i]  <= `CAI_RST_REG;
                tx_r[i]  <= `CAI_RST_REG;
                rx_r[i]  <= `CAI_RST_REG;
                blk_r[i] <= `CAI_RST_REG;
                ja_r[i]  <= `CAI_RST_REG;
            end
        end else if (wr_go && ch_ok(ADDR_I)) begin
            case (ADDR_I[3:0])
                `CAI_OFS_IRQ_EN: begin
                    en_r[ch_of(ADDR_I)] <= DATA_I & `CAI_MASK_EN;
                end
                `CAI_OFS_TX_CTL: begin
                    tx_r[ch_of(ADDR_I)] <= DATA_I & `CAI_MASK_TX;
                end
                `CAI_OFS_RX_CTL: begin
                    rx_r[ch_of(ADDR_I)] <= DATA_I & `CAI_MASK_RX;
                end
                `CAI_OFS_BLK_CTL: begin
                    blk_r[ch_of(ADDR_I)] <= DATA_I & `CAI_MASK_BLK;
                end
                `CAI_OFS_JA_CTL: begin
                    ja_r[ch_of(ADDR_I)] <= DATA_I & `CAI_MASK_JA;
                end
                default: begin
                    // read-only or unmapped offsets swallow the write
                end
            endcase
        end
    end

    // ==========================================================
    // read data path
    // ==========================================================
    reg [7:0] rd_val; // selected read value

    // unmapped channels and offsets read as zero
    always @* begin
        rd_val = 8'h00;
        if (ch_ok(ADDR_I)) begin
            case (ADDR_I[3:0])
                `CAI_OFS_IRQ_EN:   rd_val = en_r[ch_of(ADDR_I)];
                `CAI_OFS_IRQ_STAT: rd_val = stat_w[ch_of(ADDR_I)];
                `CAI_OFS_ALARM:    rd_val = alarm_w[ch_of(ADDR_I)];
                `CAI_OFS_TX_CTL:   rd_val = tx_r[ch_of(ADDR_I)];
                `CAI_OFS_RX_CTL:   rd_val = rx_r[ch_of(ADDR_I)];
                `CAI_OFS_BLK_CTL:  rd_val = blk_r[ch_of(ADDR_I)];
                `CAI_OFS_JA_CTL:   rd_val = ja_r[ch_of(ADDR_I)];
                `CAI_OFS_CNT_HI:   rd_val = cnt_r[ch_of(ADDR_I)][15:8];
                `CAI_OFS_CNT_LO:   rd_val = hold_r[ch_of(ADDR_I)];
                `CAI_OFS_CNT_HOLD: rd_val = hold_r[ch_of(ADDR_I)];
                default:           rd_val = 8'h00;
            endcase
        end
    end

    // data is caught at the start of the read and held until it ends;
    // the status clear lands on the same edge, so the host sees the
    // bits as they were before the clear
    always @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            DATA_O    <= 8'h00;
            DATA_OE_O <= 1'b0;
            RDY_O     <= 1'b0;
        end else begin
            if (rd_go)
                DATA_O <= rd_val;
            DATA_OE_O <= rd_act;
            RDY_O     <= rd_act | wr_act;
        end
    end

    // ==========================================================
    // per-channel counters and monitors
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < `CAI_NUM_CH; g = g + 1) begin : gen_ch
            // channel number at address width, so the compare is 3 bits
            localparam [2:0] CH_IDX = g;
            // read strobes decoded for this channel
            assign clr_stat[g] = rd_go && hit(ADDR_I, `CAI_OFS_IRQ_STAT) &&
                                 (ch_of(ADDR_I) == CH_IDX);
            assign cnt_rd[g]   = rd_go && hit(ADDR_I, `CAI_OFS_CNT_HI) &&
                                 (ch_of(ADDR_I) == CH_IDX);

            // attenuator counts as on when either mode bit is set
            assign ja_on[g] = ja_r[g][`CAI_B_JA0] | ja_r[g][`CAI_B_JA1];

            // a single event on the last step to the ceiling
            assign sat_ev[g] = PRBS_ERR_I[g] && !cnt_rd[g] &&
                               (cnt_r[g] == `CAI_CNT_MAX - 16'h0001);

            // saturating error counter; a high-byte read snapshots the
            // low byte and restarts it, an error in that cycle still counts
            always @(posedge CORE_CLK_I or negedge RSTN_I) begin
                if (!RSTN_I) begin
                    cnt_r[g]  <= `CAI_RST_CNT;
                    hold_r[g] <= `CAI_RST_REG;
                end else if (cnt_rd[g]) begin
                    hold_r[g] <= cnt_r[g][7:0];
                    cnt_r[g]  <= {15'h0000, PRBS_ERR_I[g]};
                end else if (PRBS_ERR_I[g] && cnt_r[g] != `CAI_CNT_MAX) begin
                    cnt_r[g]  <= cnt_r[g] + 16'h0001;
                end
            end

            // monitors, status latch and interrupt gate
            cai_chan u_chan (
                .clk_i       (CORE_CLK_I),
                .rst_n_i     (RSTN_I),
                .tx_pulse_i  (TX_PULSE_I[g]),
                .rx_los_i    (RX_LOS_I[g]),
                .rclk_tick_i (RCLK_TICK_I[g]),
                .ref_tick_i  (REF_TICK_I[g]),
                .fifo_lim_i  (JA_LIMIT_I[g]),
                .prbs_err_i  (PRBS_ERR_I[g]),
                .cnt_sat_i   (sat_ev[g]),
                .txmon_en_i  (tx_r[g][`CAI_B_TXMON]),
                .ja_on_i     (ja_on[g]),
                .irq_en_i    (en_r[g]),
                .clr_stat_i  (clr_stat[g]),
                .stat_o      (stat_w[g]),
                .alarm_o     (alarm_w[g]),
                .irq_o       (CH_IRQ_O[g])
            );

            // control registers out to the datapath
            assign TX_CTL_O[8*g+7:8*g]  = tx_r[g];
            assign RX_CTL_O[8*g+7:8*g]  = rx_r[g];
            assign BLK_CTL_O[8*g+7:8*g] = blk_r[g];
            assign JA_CTL_O[8*g+7:8*g]  = ja_r[g];
        end
    endgenerate

endmodule
`default_nettype wire

// ===== tb/cai_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the alarm register file
// ==========================================================
module cai_regs_sva (
    // clock, reset and processor port
    input wire logic        CORE_CLK_I,
    input wire logic        RSTN_I,
    input wire logic [6:0]  ADDR_I,
    input wire logic [7:0]  DATA_I,
    input wire logic [7:0]  DATA_O,
    input wire logic        DATA_OE_O,
    input wire logic        CS_N_I,
    input wire logic        RD_N_I,
    input wire logic        WR_N_I,
    input wire logic        RDY_O,
    // interrupts and control contents
    input wire logic [5:0]  CH_IRQ_O,
    input wire logic [47:0] TX_CTL_O,
    input wire logic [47:0] JA_CTL_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    // set by the first write: enables can only leave zero through one
    logic wrote;
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I)
            wrote <= 1'b0;
        else if (!CS_N_I && !WR_N_I)
            wrote <= 1'b1;
    end
    a_read_ack_time: assert property ($fell(RD_N_I) && !CS_N_I |-> ##[2:8] RDY_O && DATA_OE_O)
        else $error("read not acknowledged in time");
    a_oe_for_read: assert property ($rose(DATA_OE_O) |-> !RD_N_I && !CS_N_I)
        else $error("data bus driven without a read");
    a_ack_drop: assert property ((RD_N_I && WR_N_I) [*6] |-> !RDY_O && !DATA_OE_O)
        else $error("acknowledge held after strobes released");
    a_read_hold: assert property (DATA_OE_O && $past(DATA_OE_O) |-> $stable(DATA_O))
        else $error("read data moved while driven");
    a_unmapped_zero: assert property ($rose(DATA_OE_O) && ADDR_I[6:4] > 3'h5 |-> DATA_O == 8'h00)
        else $error("unmapped channel read not zero");
    a_tx_write: assert property ($rose(RDY_O) && !WR_N_I && ADDR_I[3:0] == 4'h4
        && ADDR_I[6:4] < 3'h6 |-> TX_CTL_O[ADDR_I[6:4] * 8 +: 8] == (DATA_I & 8'h37))
        else $error("transmit control write lost");
    a_ja_write: assert property ($rose(RDY_O) && !WR_N_I && ADDR_I[3:0] == 4'h7
        && ADDR_I[6:4] < 3'h6 |-> JA_CTL_O[ADDR_I[6:4] * 8 +: 8] == (DATA_I & 8'h0F))
        else $error("attenuator control write lost");
    a_irq_gate_reset: assert property (!wrote |-> CH_IRQ_O == 6'h00)
        else $error("interrupt with all enables at reset");
    // main scenarios reached
    c_read: cover property ($rose(DATA_OE_O));
    c_write: cover property ($rose(RDY_O) && !WR_N_I);
    c_irq: cover property (CH_IRQ_O != 6'h00);
endmodule

bind cai_regs cai_regs_sva u_cai_regs_sva (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
    .ADDR_I(ADDR_I), .DATA_I(DATA_I), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
    .CS_N_I(CS_N_I), .RD_N_I(RD_N_I), .WR_N_I(WR_N_I), .RDY_O(RDY_O),
    .CH_IRQ_O(CH_IRQ_O), .TX_CTL_O(TX_CTL_O), .JA_CTL_O(JA_CTL_O));
`default_nettype wire

// ===== tb/cai_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// host processor model on the parallel port
// ==========================================================
module cai_host (
    // clock
    input  wire logic       clk_i,
    // processor port
    output var  logic [6:0] addr_o,
    output var  logic [7:0] data_o,
    input  wire logic [7:0] data_i,
    output var  logic       cs_n_o,
    output var  logic       rd_n_o,
    output var  logic       wr_n_o,
    input  wire logic       rdy_i
);
    int timeouts = 0;  // accesses that never saw ready
    initial begin
        addr_o = 7'h00;
        data_o = 8'h00;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
    end
    // one access: drive after an edge, hold until ready is sampled high
    task automatic access(input logic w, input logic [6:0] a, input logic [7:0] d,
                          output logic [7:0] q);
        int n;
        @(posedge clk_i);
        #1;
        addr_o = a;
        data_o = d;
        cs_n_o = 1'b0;
        rd_n_o = w;
        wr_n_o = !w;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rdy_i !== 1'b1 && n < 20);
        q = data_i;
        if (n >= 20)
            timeouts++;
        #1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        // released lines stop showing the old value
        addr_o = ~a;
        data_o = ~d;
        // strobes stay high long enough for the filter to see the gap
        repeat (6) @(posedge clk_i);
        #1;
    endtask
endmodule
`default_nettype wire

// ===== tb/cai_regs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %s expected %h seen %h", w, e, g); end end
// ==========================================================
// self-checking bench for the alarm register file
// ==========================================================
module cai_regs_tb_top;
    logic       clk = 1'b0;
    logic       rst_n = 1'b0;
    logic [6:0] addr;
    logic [7:0] wdat, rdat, q;
    logic       oe, cs_n, rd_n, wr_n, rdy;
    // line side stimulus, one bit per channel
    logic [5:0] tx_pulse = 6'h00, rx_los = 6'h00, ja_lim = 6'h00, prbs = 6'h00;
    logic [5:0] rck_tick = 6'h00, ref_tick = 6'h00, irq;
    logic [47:0] rx_ctl, blk_ctl;
    int         err_total = 0, comparisons = 0, lock_mode = 0, cyc = 0;
    int         ofs [10] = '{1, 2, 3, 4, 5, 6, 7, 10, 11, 12};
    // model state: expected status and enables per channel
    logic [7:0] exp_stat [6];
    logic [7:0] exp_en [6];

    initial forever #2 clk = ~clk;

    cai_regs u_cai_regs (.CORE_CLK_I(clk), .RSTN_I(rst_n), .ADDR_I(addr), .DATA_I(wdat),
        .DATA_O(rdat), .DATA_OE_O(oe), .CS_N_I(cs_n), .RD_N_I(rd_n), .WR_N_I(wr_n),
        .RDY_O(rdy), .TX_PULSE_I(tx_pulse), .RX_LOS_I(rx_los), .RCLK_TICK_I(rck_tick),
        .REF_TICK_I(ref_tick), .JA_LIMIT_I(ja_lim), .PRBS_ERR_I(prbs), .CH_IRQ_O(irq),
        .TX_CTL_O(), .RX_CTL_O(rx_ctl), .BLK_CTL_O(blk_ctl), .JA_CTL_O());
    cai_host u_cai_host (.clk_i(clk), .addr_o(addr), .data_o(wdat), .data_i(rdat),
        .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .rdy_i(rdy));

    // channel 1 ticks: mode 1 recovered runs at twice reference, mode 2 matches
    always @(posedge clk) begin
        #1;
        cyc++;
        ref_tick = (lock_mode != 0 && cyc[0]) ? 6'h02 : 6'h00;
        rck_tick = (lock_mode == 1 || (lock_mode == 2 && cyc[0])) ? 6'h02 : 6'h00;
    end

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // a hung access ends the run at once
    task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
        u_cai_host.access(w, a, d, q);
        if (u_cai_host.timeouts != 0) begin
            err_total++;
            tally_and_finish();
        end
    endtask
    task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        `CHK("read data", e, q)
    endtask
    // status read clears, so the model clears alongside
    task automatic stat(input int c);
        rdchk(7'(c * 16 + 2), exp_stat[c]);
        exp_stat[c] = 8'h00;
    endtask
    task automatic irqchk();
        logic [5:0] e;
        for (int c = 0; c < 6; c++) e[c] = |(exp_stat[c] & exp_en[c]);
        `CHK("irq", e, irq)
    endtask
    task automatic en(input int c, input logic [7:0] d);
        exp_en[c] = d & 8'h3F;
        acc(1'b1, 7'(c * 16 + 1), d);
    endtask
    task automatic line(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic pulse(input int c);
        prbs[c] = 1'b1;
        line(1);
        prbs[c] = 1'b0;
    endtask

    initial begin
        void'($urandom(33));
        for (int c = 0; c < 6; c++) begin
            exp_stat[c] = 8'h00;
            exp_en[c] = 8'h00;
        end
        line(4);
        rst_n = 1'b1;
        // reset values, channels 6 and 7 unmapped
        for (int c = 0; c < 8; c++)
            foreach (ofs[i]) rdchk(7'(c * 16 + ofs[i]), 8'h00);
        acc(1'b1, 7'h61, 8'h3F);
        rdchk(7'h61, 8'h00);
        acc(1'b1, 7'h55, 8'hFF);
        `CHK("rx ctl", 8'h3F, rx_ctl[47:40])
        rdchk(7'h55, 8'h3F);
        $display("test reset ended");
        // signal loss both ways, gated and ungated, every channel
        for (int c = 0; c < 6; c++) begin
            en(c, 8'($urandom) | 8'h02);
            rdchk(7'(c * 16 + 1), exp_en[c]);
            rx_los[c] = 1'b1;
            exp_stat[c] = 8'h02;
            line(3);
            irqchk();
            stat(c);
            stat(c);
            irqchk();
            en(c, exp_en[c] & 8'hFD);
            rx_los[c] = 1'b0;
            exp_stat[c] = 8'h02;
            line(3);
            irqchk();
            stat(c);
        end
        $display("test signal loss ended");
        // driver monitor: nothing before 128 quiet cycles, then both changes
        tx_pulse[0] = 1'b1;
        acc(1'b1, 7'h04, 8'h20);
        en(0, 8'h01);
        stat(0);
        tx_pulse[0] = 1'b0;
        line(100);
        stat(0);
        line(40);
        exp_stat[0] = 8'h01;
        irqchk();
        stat(0);
        rdchk(7'h03, 8'h01);
        tx_pulse[0] = 1'b1;
        line(1);
        tx_pulse[0] = 1'b0;
        exp_stat[0] = 8'h01;
        stat(0);
        rdchk(7'h03, 8'h00);
        acc(1'b1, 7'h04, 8'h00);
        $display("test driver quiet ended");
        // fifo limit ignored with attenuator off, then entering and leaving
        en(2, 8'h08);
        ja_lim[2] = 1'b1;
        line(3);
        irqchk();
        stat(2);
        acc(1'b1, 7'h27, 8'h01);
        exp_stat[2] = 8'h08;
        irqchk();
        stat(2);
        ja_lim[2] = 1'b0;
        exp_stat[2] = 8'h08;
        line(3);
        stat(2);
        acc(1'b1, 7'h27, 8'hFA);
        $display("test fifo limit ended");
        // lock lost with recovered clock far off, then regained
        en(1, 8'h04);
        lock_mode = 1;
        line(4500);
        exp_stat[1] = 8'h04;
        irqchk();
        stat(1);
        lock_mode = 2;
        line(4500);
        exp_stat[1] = 8'h04;
        stat(1);
        lock_mode = 0;
        $display("test lock ended");
        // prbs errors back to back, then with the enable off
        en(4, 8'h10);
        prbs[4] = 1'b1;
        line(2);
        prbs[4] = 1'b0;
        exp_stat[4] = 8'h10;
        line(2);
        irqchk();
        stat(4);
        en(4, 8'h00);
        pulse(4);
        exp_stat[4] = 8'h10;
        line(2);
        irqchk();
        stat(4);
        // counter one short of saturation, then the last error
        acc(1'b1, 7'h36, 8'h20);
        `CHK("block ctl", 8'h20, blk_ctl[31:24])
        en(3, 8'h20);
        prbs[3] = 1'b1;
        line(65534);
        prbs[3] = 1'b0;
        exp_stat[3] = 8'h10;
        line(2);
        irqchk();
        stat(3);
        pulse(3);
        exp_stat[3] = 8'h30;
        line(2);
        irqchk();
        stat(3);
        rdchk(7'h3A, 8'hFF);
        rdchk(7'h3B, 8'hFF);
        $display("test prbs ended");
        tally_and_finish();
    end
endmodule
`default_nettype wire
